// ==== lmws_bank_timer.sv ====
/*
 * One disable timer per bank, counted in mclk cycles from a period given in bus clocks.
 * Assumes the core pulses tmr_start only at the end of a terminating word.
 */
`timescale 1ns/10ps
module lmws_bank_timer (
	input  wire logic  i_mclk,
	input  wire logic  i_resetn,
	input  wire logic  i_clk_en,
	lmws_seq_if.timer  seq
);
	typedef struct packed {
		logic [lmws_pkg::BANKS-1:0][lmws_pkg::TMR_W-1:0] cnt;
	} lmws_tmr_t;

	lmws_tmr_t                     st_reg;
	lmws_tmr_t                     st_next;
	logic [lmws_pkg::TMR_W-1:0]    load;
	logic [lmws_pkg::BANKS-1:0][lmws_pkg::TMR_W-1:0] cnt_next;

	// Period is in bus clocks; multiplying by the divider converts it to mclk cycles.
	assign load = {4'h0, seq.tmr_period} * {4'h0, seq.bus_clock_divider};

	genvar b;
	generate
		for (b = 0; b < lmws_pkg::BANKS; b++) begin : g_bank
			assign cnt_next[b] = (seq.tmr_start && seq.tmr_bank == b) ? load :
				(st_reg.cnt[b] != '0) ? st_reg.cnt[b] - 8'h01 : st_reg.cnt[b];
			assign seq.bank_blocked[b] = st_reg.cnt[b] != '0;
		end
	endgenerate

	always_comb begin
		st_next     = st_reg;
		st_next.cnt = cnt_next;
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			st_reg <= '0;
		else if (i_clk_en)
			st_reg <= st_next;
	end
endmodule // lmws_bank_timer

// ==== lmws_mem_model.sv ====
/* Memory device model at the far side of the local bus: stretches an access with its wait line.
   Assumes its chip select and the wait line share the sequencer clock. */
`timescale 1ns/10ps
module lmws_mem_model (
	input  wire logic       i_mclk,
	input  wire logic       i_cs_n,
	input  wire logic [3:0] i_stall,
	output logic            o_wait
);
	logic [3:0] left_reg = 4'h0;
	logic       armed_reg = 1'b1;
	// Stalls once per select, so a chip select frozen by the stall cannot retrigger it.
	assign o_wait = (left_reg != 4'h0);
	always @(posedge i_mclk) begin
		armed_reg <= i_cs_n | (armed_reg & (i_stall == 4'h0));
		if (!i_cs_n && armed_reg)
			left_reg <= i_stall;
		else if (left_reg != 4'h0)
			left_reg <= left_reg - 4'h1;
	end
endmodule // lmws_mem_model

// ==== lmws_phase_gen.sv ====
/*
 * Splits each bus clock cycle into quarter phases (half phases at divider 2).
 * Assumes the core holds run high for the whole of a pattern.
 */
`timescale 1ns/10ps
module lmws_phase_gen (
	input  wire logic  i_mclk,
	input  wire logic  i_resetn,
	input  wire logic  i_clk_en,
	lmws_seq_if.phase  seq
);
	typedef struct packed {
		logic       sub;
		logic [1:0] quarter;
	} lmws_phase_t;

	lmws_phase_t st_reg;
	lmws_phase_t st_next;
	logic        sub_last;

	assign sub_last          = (seq.bus_clock_divider == lmws_pkg::DIV_8) ? st_reg.sub : 1'b1;
	assign seq.quarter       = st_reg.quarter;
	assign seq.quarter_start = ~st_reg.sub;
	assign seq.cycle_last    = seq.run & sub_last & ((st_reg.quarter == 2'h3) |
		((seq.bus_clock_divider == lmws_pkg::DIV_2) & (st_reg.quarter == 2'h2)));

	always_comb begin
		st_next = st_reg;
		if (!seq.run) begin
			st_next = '0;
		end else if (!seq.hold) begin
			if (!sub_last) begin
				st_next.sub = 1'b1;
			end else begin
				st_next.sub = 1'b0;
				if (seq.cycle_last)
					st_next.quarter = 2'h0;
				else if (seq.bus_clock_divider == lmws_pkg::DIV_2)
					st_next.quarter = st_reg.quarter + 2'h2;
				else
					st_next.quarter = st_reg.quarter + 2'h1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			st_reg <= '0;
		else if (i_clk_en)
			st_reg <= st_next;
	end
endmodule // lmws_phase_gen

// ==== lmws_pkg.sv ====
/*
 * Shared constants and types for the local bus microword sequencer.
 * Assumes a single 50 MHz clock domain and word bits numbered 0 = lsb.
 */
package lmws_pkg;
	localparam int WORD_W      = 32;
	localparam int RAM_DEPTH   = 64;
	localparam int PC_W        = 6;
	localparam int BANKS       = 8;
	localparam int BANK_W      = 3;
	localparam int GPL_LINES   = 6;
	localparam int LAD_W       = 16;
	localparam int LA_W        = 5;
	localparam int LOOPCNT_W   = 4;
	localparam int PERIOD_W    = 4;
	localparam int TMR_W       = 8;
	localparam int MCLK_MHZ    = 50;
	localparam int MCLK_NS     = 1000 / MCLK_MHZ;

	// Microword field positions.
	localparam int CS_LSB      = 0;
	localparam int BS_LSB      = 4;
	localparam int L0_LO_LSB   = 8;
	localparam int L0_HI_LSB   = 10;
	localparam int L1_LSB      = 12;
	localparam int L4_FIRST    = 18;
	localparam int L4_SECOND   = 19;
	localparam int REDO_LSB    = 22;
	localparam int LOOP_BIT    = 24;
	localparam int EXCEPTION_BRANCH_ENABLE_BIT    = 25;
	localparam int AMX_LSB     = 26;
	localparam int NA_BIT      = 28;
	localparam int UTA_BIT     = 29;
	localparam int BANK_TIMER_START_BIT    = 30;
	localparam int LAST_BIT    = 31;

	localparam logic [1:0] L0_ADDR    = 2'h0;
	localparam logic [1:0] L0_HIGH    = 2'h3;
	localparam logic [1:0] AMX_PLAIN  = 2'h0;
	localparam logic [1:0] AMX_ROWCOL = 2'h2;
	localparam logic [1:0] AMX_MAR    = 2'h3;
	localparam logic [3:0] DIV_2      = 4'h2;
	localparam logic [3:0] DIV_8      = 4'h8;
	localparam logic [4:0] ROW_SHIFT  = 5'h08;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN} lmws_state_t;
endpackage

// ==== lmws_seq_if.sv ====
/*
 * Carrier between the sequencer core, its phase generator and bank timers.
 * Assumes all three sit on the same clock and reset.
 */
`timescale 1ns/10ps
interface lmws_seq_if;
	logic [3:0]                bus_clock_divider;
	logic                      run;
	logic                      hold;
	logic [1:0]                quarter;
	logic                      quarter_start;
	logic                      cycle_last;
	logic                      tmr_start;
	logic [lmws_pkg::BANK_W-1:0]   tmr_bank;
	logic [lmws_pkg::PERIOD_W-1:0] tmr_period;
	logic [lmws_pkg::BANKS-1:0]    bank_blocked;

	modport phase (input bus_clock_divider, run, hold,
		output quarter, quarter_start, cycle_last);
	modport timer (input bus_clock_divider, tmr_start, tmr_bank, tmr_period,
		output bank_blocked);
	modport core (output bus_clock_divider, run, hold, tmr_start, tmr_bank, tmr_period,
		input quarter, quarter_start, cycle_last, bank_blocked);
endinterface

// ==== lmws_sequencer.sv ====
/*
 * Microword sequencer of a programmable memory machine: pattern store,
 * word sequencing and generation of chip select, byte lanes and general lines.
 * Assumes requests, timeout and wait inputs are synchronous to i_mclk.
 */
`timescale 1ns/10ps
module lmws_sequencer (
	input  wire logic                          i_mclk,
	input  wire logic                          i_resetn,
	input  wire logic                          i_clk_en,
	input  wire logic                          i_ram_wr_en,
	input  wire logic [lmws_pkg::PC_W-1:0]     i_ram_wr_addr,
	input  wire logic [lmws_pkg::WORD_W-1:0]   i_ram_wr_data,
	input  wire logic                          i_req_valid,
	input  wire logic [lmws_pkg::PC_W-1:0]     i_req_start_addr,
	input  wire logic [lmws_pkg::BANK_W-1:0]   i_req_bank,
	input  wire logic [31:0]                   i_req_addr,
	input  wire logic                          i_req_read,
	input  wire logic                          i_req_byte_only,
	input  wire logic [lmws_pkg::LOOPCNT_W-1:0] i_req_loop_count,
	input  wire logic                          i_port_size,
	input  wire logic [3:0]                    i_bus_clock_divider,
	input  wire logic [4:0]                    i_line0_address_select,
	input  wire logic                          i_line4_mode_select,
	input  wire logic                          i_machine_wait_input,
	input  wire logic                          i_bus_timeout,
	input  wire logic [lmws_pkg::PC_W-1:0]     i_exception_start_address,
	input  wire logic [2:0]                    i_row_column_mux_select,
	input  wire logic [31:0]                   i_memory_address_register,
	input  wire logic [lmws_pkg::PERIOD_W-1:0] i_bank_disable_period,
	output logic                               o_req_taken,
	output logic                               o_busy,
	output logic                               o_done,
	output logic [lmws_pkg::BANKS-1:0]         o_bank_chip_select_n,
	output logic [1:0]                         o_byte_lane_select_n,
	output logic [lmws_pkg::GPL_LINES-1:0]     o_general_purpose_lines,
	output logic                               o_line4_oe_n,
	output logic                               o_address_latch_strobe,
	output logic [lmws_pkg::LAD_W-1:0]         o_muxed_address_data_lines,
	output logic [lmws_pkg::LA_W-1:0]          o_low_address_lines,
	output logic                               o_transfer_ack,
	output logic                               o_data_sample
);
	typedef struct packed {
		lmws_pkg::lmws_state_t               state;
		logic [lmws_pkg::PC_W-1:0]           pc;
		logic [1:0]                          redo_cnt;
		logic                                loop_seen;
		logic [lmws_pkg::PC_W-1:0]           loop_start;
		logic [lmws_pkg::LOOPCNT_W-1:0]      loop_cnt;
		logic                                in_exc;
		logic                                exc_pending;
		logic                                first_word;
		logic                                word_first;
		logic [1:0]                          prev_amx;
		logic [31:0]                         addr;
		logic [lmws_pkg::BANK_W-1:0]         bank;
		logic                                read;
		logic                                port16;
		logic                                byte_only;
		logic                                sample_due;
		logic                                req_taken;
		logic                                done;
		logic                                busy;
		logic [lmws_pkg::BANKS-1:0]          cs_n;
		logic [1:0]                          bls_n;
		logic [lmws_pkg::GPL_LINES-1:0]      gpl;
		logic                                l4_oe_n;
		logic                                ale;
		logic [lmws_pkg::LAD_W-1:0]          muxed_address_data_lines;
		logic [lmws_pkg::LA_W-1:0]           la;
		logic                                ack;
		logic                                sample;
	} lmws_core_t;

	lmws_core_t                       st_reg;
	lmws_core_t                       st_next;
	logic [lmws_pkg::WORD_W-1:0]      pattern_ram [lmws_pkg::RAM_DEPTH];
	logic [lmws_pkg::WORD_W-1:0]      w;
	logic                             running;
	logic                             step;
	logic                             redo_done;
	logic                             loop_end;
	logic                             terminate;
	logic [1:0]                       address_source_select;
	logic [31:0]                      src_addr;
	logic [1:0]                       lane_en;
	logic [1:0]                       l0_code;
	logic                             half;
	logic [lmws_pkg::LOOPCNT_W-1:0]   loop_dec;

	lmws_seq_if seq ();

	lmws_phase_gen u_phase (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_clk_en (i_clk_en),
		.seq      (seq.phase)
	);

	lmws_bank_timer u_timer (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_clk_en (i_clk_en),
		.seq      (seq.timer)
	);

	// The store is written by software loading; the sequencer only reads it.
	always_ff @(posedge i_mclk) begin
		if (i_clk_en && i_ram_wr_en)
			pattern_ram[i_ram_wr_addr] <= i_ram_wr_data;
	end

	assign w         = pattern_ram[st_reg.pc];
	assign running   = st_reg.state == lmws_pkg::ST_RUN;
	assign address_source_select       = w[lmws_pkg::AMX_LSB +: 2];
	assign half      = seq.quarter[1];
	assign redo_done = st_reg.redo_cnt == w[lmws_pkg::REDO_LSB +: 2];
	assign loop_end  = w[lmws_pkg::LOOP_BIT] & st_reg.loop_seen & (st_reg.pc != st_reg.loop_start);
	assign loop_dec  = st_reg.loop_cnt - 4'h1;
	assign seq.hold  = running & i_line4_mode_select & w[lmws_pkg::L4_SECOND] &
		i_machine_wait_input;
	assign step      = running & seq.cycle_last & ~seq.hold;
	assign terminate = step & ~st_reg.exc_pending & redo_done & w[lmws_pkg::LAST_BIT];
	assign seq.run   = running;
	assign seq.bus_clock_divider = i_bus_clock_divider;
	assign seq.tmr_start  = terminate & w[lmws_pkg::BANK_TIMER_START_BIT];
	assign seq.tmr_bank   = st_reg.bank;
	assign seq.tmr_period = i_bank_disable_period;

	always_comb begin
		case (address_source_select)
			lmws_pkg::AMX_PLAIN:  src_addr = st_reg.addr;
			lmws_pkg::AMX_ROWCOL: src_addr = st_reg.addr >> (ROW_SHIFT_CALC(i_row_column_mux_select));
			lmws_pkg::AMX_MAR:    src_addr = i_memory_address_register;
			default:              src_addr = 32'h0;
		endcase
	end

	function automatic logic [4:0] ROW_SHIFT_CALC(input logic [2:0] sel);
		ROW_SHIFT_CALC = lmws_pkg::ROW_SHIFT + {2'h0, sel};
	endfunction

	// Lane 0 carries the even byte; a 16-bit port moves one or both lanes, and no lane moves while in the exception routine.
	always_comb begin
		if (!st_reg.port16)
			lane_en = 2'h1;
		else if (st_reg.byte_only)
			lane_en = st_reg.addr[0] ? 2'h2 : 2'h1;
		else
			lane_en = 2'h3;
		if (st_reg.in_exc)
			lane_en = 2'h0;
	end

	assign l0_code = half ? w[lmws_pkg::L0_HI_LSB +: 2] : w[lmws_pkg::L0_LO_LSB +: 2];

	always_comb begin
		st_next           = st_reg;
		st_next.req_taken = 1'b0;
		st_next.done      = 1'b0;
		st_next.sample    = 1'b0;
		// A timeout seen during the freeze is still remembered.
		if (running && i_bus_timeout && w[lmws_pkg::EXCEPTION_BRANCH_ENABLE_BIT] && !st_reg.in_exc)
			st_next.exc_pending = 1'b1;
		case (st_reg.state)
			lmws_pkg::ST_IDLE: begin
				// Without a running timer the bank is released.
				if (!seq.bank_blocked[st_reg.bank]) begin
					st_next.cs_n  = '1;
					st_next.bls_n = '1;
				end
				st_next.ack = 1'b0;
				st_next.ale = 1'b0;
				if (i_req_valid && !seq.bank_blocked[i_req_bank]) begin
					st_next.state      = lmws_pkg::ST_RUN;
					st_next.req_taken  = 1'b1;
					st_next.pc         = i_req_start_addr;
					st_next.bank       = i_req_bank;
					st_next.addr       = i_req_addr;
					st_next.read       = i_req_read;
					st_next.port16     = i_port_size;
					st_next.byte_only  = i_req_byte_only;
					st_next.loop_cnt   = i_req_loop_count;
					st_next.redo_cnt   = 2'h0;
					st_next.loop_seen  = 1'b0;
					st_next.in_exc     = 1'b0;
					st_next.exc_pending = 1'b0;
					st_next.first_word = 1'b1;
					// A sample owed by an earlier read must not fire in this request.
					st_next.sample_due = 1'b0;
					st_next.word_first = 1'b1;
				end
			end
			lmws_pkg::ST_RUN: begin
				if (!seq.hold) begin
					st_next.cs_n = '1;
					st_next.cs_n[st_reg.bank] = w[lmws_pkg::CS_LSB + seq.quarter];
					st_next.bls_n = {2{w[lmws_pkg::BS_LSB + seq.quarter]}} | ~lane_en;
					if (l0_code == lmws_pkg::L0_ADDR)
						st_next.gpl[0] = st_reg.addr[i_line0_address_select];
					else
						st_next.gpl[0] = l0_code == lmws_pkg::L0_HIGH;
					for (int n = 1; n < lmws_pkg::GPL_LINES; n++)
						st_next.gpl[n] = w[lmws_pkg::L1_LSB + 2 * (n - 1) + half];
					st_next.l4_oe_n = i_line4_mode_select;
					st_next.ale = st_reg.word_first &&
						(st_reg.first_word || address_source_select != st_reg.prev_amx);
					st_next.muxed_address_data_lines = src_addr[lmws_pkg::LAD_W-1:0];
					st_next.la  = src_addr[lmws_pkg::LA_W-1:0];
					st_next.ack = w[lmws_pkg::UTA_BIT];
					// Late sampling is carried into the first quarter of the next cycle.
					if (st_reg.read && w[lmws_pkg::UTA_BIT] && seq.quarter_start) begin
						if (i_line4_mode_select && w[lmws_pkg::L4_FIRST])
							st_next.sample = seq.quarter == 2'h2;
						else if (seq.quarter == 2'h0)
							st_next.sample_due = 1'b1;
					end
					if (st_reg.sample_due && seq.quarter == 2'h0 && seq.quarter_start &&
						!st_reg.word_first) begin
						st_next.sample     = 1'b1;
						st_next.sample_due = 1'b0;
					end
					if (st_reg.sample_due && st_reg.word_first && seq.quarter_start) begin
						st_next.sample     = 1'b1;
						st_next.sample_due = 1'b0;
					end
					st_next.word_first = 1'b0;
				end
				if (step) begin
					if (w[lmws_pkg::NA_BIT])
						st_next.addr = st_reg.addr + (st_reg.port16 ? 32'h2 : 32'h1);
					st_next.prev_amx   = address_source_select;
					st_next.first_word = 1'b0;
					st_next.word_first = 1'b1;
					if (st_reg.exc_pending) begin
						st_next.pc          = i_exception_start_address;
						st_next.in_exc      = 1'b1;
						st_next.exc_pending = 1'b0;
						st_next.redo_cnt    = 2'h0;
						st_next.loop_seen   = 1'b0;
					end else if (!redo_done) begin
						st_next.redo_cnt   = st_reg.redo_cnt + 2'h1;
						st_next.word_first = 1'b0;
					end else begin
						st_next.redo_cnt = 2'h0;
						if (w[lmws_pkg::LAST_BIT]) begin
							st_next.state = lmws_pkg::ST_IDLE;
							st_next.done  = 1'b1;
						end else if (loop_end) begin
							st_next.loop_cnt = loop_dec;
							if (loop_dec != '0) begin
								st_next.pc = st_reg.loop_start;
							end else begin
								st_next.pc        = st_reg.pc + 6'h1;
								st_next.loop_seen = 1'b0;
							end
						end else begin
							if (w[lmws_pkg::LOOP_BIT] && !st_reg.loop_seen) begin
								st_next.loop_seen  = 1'b1;
								st_next.loop_start = st_reg.pc;
							end
							st_next.pc = st_reg.pc + 6'h1;
						end
					end
				end
			end
			default: st_next.state = lmws_pkg::ST_IDLE;
		endcase
		st_next.busy = st_next.state == lmws_pkg::ST_RUN;
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg         <= '0;
			st_reg.cs_n    <= '1;
			st_reg.bls_n   <= '1;
			st_reg.l4_oe_n <= 1'b1;
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	assign o_req_taken                = st_reg.req_taken;
	assign o_busy                     = st_reg.busy;
	assign o_done                     = st_reg.done;
	assign o_bank_chip_select_n       = st_reg.cs_n;
	assign o_byte_lane_select_n       = st_reg.bls_n;
	assign o_general_purpose_lines    = st_reg.gpl;
	assign o_line4_oe_n               = st_reg.l4_oe_n;
	assign o_address_latch_strobe     = st_reg.ale;
	assign o_muxed_address_data_lines = st_reg.muxed_address_data_lines;
	assign o_low_address_lines        = st_reg.la;
	assign o_transfer_ack             = st_reg.ack;
	assign o_data_sample              = st_reg.sample;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn || !i_clk_en);

	a_seq_next_word: assert property (
		step && !st_reg.exc_pending && redo_done && !w[lmws_pkg::LAST_BIT] &&
		!w[lmws_pkg::LOOP_BIT] |=> st_reg.pc == $past(st_reg.pc) + 6'h1)
		else $error("word did not advance to the next address");
	a_redo_repeat: assert property (
		step && !st_reg.exc_pending && !redo_done |=>
		st_reg.pc == $past(st_reg.pc) && st_reg.redo_cnt == $past(st_reg.redo_cnt) + 2'h1)
		else $error("repeat did not rerun the word");
	a_exc_branch: assert property (
		step && st_reg.exc_pending |=>
		st_reg.pc == $past(i_exception_start_address) && st_reg.in_exc)
		else $error("exception branch missed");
	a_exc_ignored: assert property (
		running && i_bus_timeout && !w[lmws_pkg::EXCEPTION_BRANCH_ENABLE_BIT] && !st_reg.exc_pending |=>
		!st_reg.exc_pending)
		else $error("timeout taken in a word without exception enable");
	a_wait_freeze: assert property (
		seq.hold |=> $stable(o_bank_chip_select_n) && $stable(o_general_purpose_lines) &&
		$stable(o_byte_lane_select_n))
		else $error("outputs moved during wait");
	a_ack_cycle: assert property (
		running && !seq.hold && w[lmws_pkg::UTA_BIT] |=> o_transfer_ack)
		else $error("acknowledge missing");
	a_last_done: assert property (
		terminate |=> o_done && !o_busy ##1 !o_done)
		else $error("pattern end did not complete");
	a_timer_last: assert property (
		seq.tmr_start |-> w[lmws_pkg::LAST_BIT] && step)
		else $error("timer started outside an end word");
	a_half_phase: assert property (
		running && i_bus_clock_divider == lmws_pkg::DIV_2 |-> !seq.quarter[0])
		else $error("quarter phase used at divider 2");
	a_loop_return: assert property (
		step && !st_reg.exc_pending && redo_done && loop_end && loop_dec != '0 |=>
		st_reg.pc == $past(st_reg.loop_start))
		else $error("loop did not return to its start");
endmodule // lmws_sequencer

// ==== lmws_sequencer_test.sv ====
/* Self-checking bench for the microword sequencer with a stalling memory model.
   Assumes a 50 MHz clock and the hand-over timing of the sequencer. */
`timescale 1ns/10ps
module lmws_sequencer_test;
	logic        mclk, resetn, req_valid, wr_en, tmo, l4, mwait, ps, taken, busy, done, oe_n, ack;
	logic [5:0]  wr_addr, start, gpl, g1, g3;
	logic [31:0] wr_data, addr, memory_address_register, w;
	logic [2:0]  bank;
	logic        bo, ale;
	logic [1:0]  bls, b1;
	logic [4:0]  la, la1;
	logic [15:0] muxed_address_data_lines, lad1;
	logic [3:0]  div, loops, period, stall;
	logic [7:0]  cs_n;
	integer      seed = 32'h5f3e2026;
	integer      err_total = 0, samples_checked = 0, n_cs, n_ack, n_ale, waited, r, k;
	lmws_sequencer i_dut (.i_mclk(mclk), .i_resetn(resetn), .i_clk_en(1'b1),
		.i_ram_wr_en(wr_en), .i_ram_wr_addr(wr_addr), .i_ram_wr_data(wr_data),
		.i_req_valid(req_valid), .i_req_start_addr(start), .i_req_bank(bank),
		.i_req_addr(addr), .i_req_read(1'b0), .i_req_byte_only(bo),
		.i_req_loop_count(loops), .i_port_size(ps), .i_bus_clock_divider(div),
		.i_line0_address_select(5'h00), .i_line4_mode_select(l4),
		.i_machine_wait_input(mwait), .i_bus_timeout(tmo), .i_exception_start_address(6'h30),
		.i_row_column_mux_select(3'h0), .i_memory_address_register(memory_address_register),
		.i_bank_disable_period(period), .o_req_taken(taken), .o_busy(busy), .o_done(done),
		.o_bank_chip_select_n(cs_n), .o_byte_lane_select_n(bls), .o_general_purpose_lines(gpl),
		.o_line4_oe_n(oe_n), .o_address_latch_strobe(ale), .o_muxed_address_data_lines(muxed_address_data_lines),
		.o_low_address_lines(la), .o_transfer_ack(ack), .o_data_sample());
	lmws_mem_model i_mem (.i_mclk(mclk), .i_cs_n(cs_n[bank]), .i_stall(stall), .o_wait(mwait));
	initial mclk = 1'b0;
	always #10 mclk = ~mclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Leaves the write strobe up, so back-to-back loads never assign it twice in one step.
	task automatic ld(input logic [5:0] a, input logic [31:0] d);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge mclk);
		#1;
	endtask
	task automatic run(input logic [5:0] s, input logic [2:0] b);
		wr_en = 1'b0;
		start = s;
		bank = b;
		req_valid = 1'b1;
		waited = 0;
		n_cs = 0;
		n_ack = 0;
		n_ale = 0;
		while (taken !== 1'b1 && waited < 400) begin
			@(posedge mclk);
			#1;
			waited++;
		end
		req_valid = 1'b0;
		for (int i = 0; i < 400; i++) begin
			if (cs_n[b] === 1'b0) begin
				n_cs++;
				if (n_cs == 1) begin
					g1 = gpl;
					b1 = bls;
					la1 = la;
					lad1 = muxed_address_data_lines;
				end
				if (n_cs == 3) g3 = gpl;
			end
			n_ack += (ack === 1'b1);
			n_ale += (ale === 1'b1);
			// The last phase of the end word stands in the same cycle as the done pulse.
			if (done === 1'b1)
				break;
			@(posedge mclk);
			#1;
		end
		chk(done, 1);
		chk(busy, 0);
	endtask
	function automatic logic [5:0] gexp(input logic [31:0] v, input int h);
		return {v[20+h], v[18+h], v[16+h], v[14+h], v[12+h], v[8+2*h]};
	endfunction
	// Active-low lanes: bit 0 is the even byte, an 8-bit port uses that lane alone.
	function automatic logic [1:0] lanes_n(input logic p16, input logic one, input logic a0);
		return p16 ? (one ? (a0 ? 2'h1 : 2'h2) : 2'h0) : 2'h2;
	endfunction
	logic [3:0] tdiv [5] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h4};
	logic [3:0] tcs [5] = '{4'ha, 4'ha, 4'ha, 4'h5, 4'h5};
	int         tlow [5] = '{2, 2, 4, 0, 2};
	initial begin
		resetn = 0; req_valid = 0; wr_en = 0; wr_addr = 0; wr_data = 0; tmo = 0; l4 = 0;
		start = 0; bank = 0; div = 4'h4; loops = 4'h1; period = 4'h1; stall = 4'h0; bo = 0;
		addr = $random(seed); memory_address_register = $random(seed); ps = 1'($random(seed));
		repeat (16) @(posedge mclk);
		#1;
		resetn = 1;
		chk(cs_n, 8'hff);
		for (r = 0; r < 5; r++) begin
			div = tdiv[r];
			ld(6'h00, 32'ha000_0000 | tcs[r]);
			run(6'h00, 3'h3);
			chk(n_cs, tlow[r]);
			chk(n_ack, tdiv[r]);
			chk(n_ale, 1);
		end
		$display("cs timing test done");
		div = 4'h4;
		for (r = 0; r < 4; r++) begin
			ld(6'h10, 32'h2000_0000 | (r << 22));
			ld(6'h11, 32'h8c00_0000);
			run(6'h10, 3'h1);
			chk(n_ack, 4 * (r + 1));
			chk(n_ale, 2);
			loops = 4'(r + 1);
			ld(6'h14, 32'h2100_0000);
			ld(6'h15, 32'h0100_0000);
			ld(6'h16, 32'h8000_0000);
			run(6'h14, 3'h4);
			chk(n_ack, 4 * (r + 1));
			chk(n_ale, 1);
		end
		$display("redo and loop test done");
		for (r = 0; r < 8; r++) begin
			w = 32'h8000_0000 | ($random(seed) & 32'h003f_f000) | (32'h2 << 8) | (32'h3 << 10);
			w = w ^ ($random(seed) & 32'h0000_0500);
			ps = 1'($random(seed));
			bo = 1'($random(seed));
			addr = $random(seed);
			ld(6'h20, w);
			run(6'h20, 3'($random(seed)));
			chk(g1, gexp(w, 0));
			chk(g3, gexp(w, 1));
			chk(b1, lanes_n(ps, bo, addr[0]));
			chk(la1, addr[4:0]);
			chk(lad1, addr[15:0]);
		end
		chk(oe_n, 0);
		$display("general line test done");
		ld(6'h30, 32'ha000_0000);
		for (r = 0; r < 2; r++) begin
			ld(6'h24, r << 25);
			ld(6'h25, 32'h8000_0000);
			tmo = 1;
			run(6'h24, 3'h2);
			tmo = 0;
			chk(n_ack, 4 * r);
		end
		$display("exception test done");
		period = 4'h1 + 4'($random(seed) & 7);
		ld(6'h28, 32'hc000_0000);
		ld(6'h29, 32'h8000_0000);
		ld(6'h2a, 32'h4000_0000);
		ld(6'h2b, 32'h8000_0000);
		run(6'h28, 3'h2);
		run(6'h29, 3'h5);
		chk(waited <= 3, 1);
		// Five edges of the other bank's pattern already count against the hold-off.
		run(6'h29, 3'h2);
		chk(waited, (period * 4 > 5) ? period * 4 - 4 : 1);
		run(6'h2a, 3'h6);
		run(6'h29, 3'h6);
		chk(waited <= 3, 1);
		$display("disable timer test done");
		l4 = 1;
		ld(6'h2c, 32'h8008_0000);
		for (r = 0; r < 3; r++) begin
			k = 1 + ($random(seed) & 7);
			stall = 4'(k);
			run(6'h2c, 3'h0);
			chk(n_cs, 4 + k);
			chk(oe_n, 1);
		end
		$display("wait test done");
		end_of_test;
	end
	initial begin
		#200000;
		err_total++;
		end_of_test;
	end
endmodule // lmws_sequencer_test
